// ==== ldgrp_core.sv ====
// executor for the data load and store instruction group
// Notes on behaviour
// - indexed immediate store via second index writes byte at index plus displacement, 19 states
// - displacement byte is signed two's complement
// - register field: 111 accumulator, 000-101 six general registers, others invalid
// - absolute accumulator store writes to operand address, 13 states
// - first address operand byte is low half, second high half
// - prefixed pair store: pair field selects count/destination/pointer/stack; low then high
// - prefixed pair absolute store takes 20 states
// - pointer pair absolute store writes low then high, 17 states
// - first index absolute store writes low then high, 20 states
// - second index absolute store writes low then high, 20 states
// - refresh load copies accumulator into refresh register, 9 states
// - pointer-indirect load reads byte at pointer pair into register, 7 states
// - indexed load via first index reads index plus displacement, 19 states
// - indexed load and store via second index use index plus displacement, 19 states
// - immediate load places operand byte into register, 7 states
// - move copies source field register into destination field register
// - no instruction of the group alters the flags
// - register move is one machine cycle of 4 states
// - second index absolute load takes low byte then high byte
`timescale 1ns/100ps
`default_nettype none
module ldgrp_core
    import ldgrp_pkg::*;
#(
    parameter logic [15:0] START_PC = 16'h0000
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output ldgrp_pkg::ldgrp_req_t o_mem_req,
    output logic o_mem_valid,
    output ldgrp_pkg::ldgrp_regs_t o_regs,
    output logic [15:0] o_pc,
    output logic o_done,
    output logic [4:0] o_tstates,
    output logic o_illegal
);
    import ldgrp_pkg::*;

    typedef enum logic [3:0] {
        ST_FETCH, ST_FETCH2, ST_DISP, ST_LO, ST_HI, ST_IMM,
        ST_WR1, ST_WR2, ST_RD1, ST_RD2, ST_DONE
    } ldgrp_state_t;

    // instruction kinds decoded after opcode fetch
    typedef enum logic [3:0] {
        K_NONE, K_MOVE, K_LDIMM, K_LDIND, K_STIND, K_STIMM, K_STACC,
        K_ST16, K_LD16, K_REFRESH
    } ldgrp_kind_t;

    ldgrp_state_t state_ff, nxt_state;
    ldgrp_kind_t kind_ff, nxt_kind;
    ldgrp_regs_t regs_ff, nxt_regs;
    ldgrp_req_t req_ff, nxt_req;
    logic valid_ff, nxt_valid;
    logic [15:0] pc_ff, nxt_pc;
    logic [15:0] addr_ff, nxt_addr;
    logic [15:0] data_ff, nxt_data;
    logic [7:0] disp_ff, nxt_disp;
    logic [7:0] op_ff, nxt_op;
    logic [1:0] pfx_ff, nxt_pfx; // 0 none, 1 first index, 2 second index, 3 extended
    logic done_ff, nxt_done;
    logic [4:0] tst_ff, nxt_tst;
    logic [4:0] tacc_ff, nxt_tacc;
    logic ill_ff, nxt_ill;
    logic [15:0] ea_base, ea_out;
    logic ea_disp;

    // read a register by select field; invalid code reads zero
    function automatic logic [7:0] rd_reg(input ldgrp_regs_t r, input logic [2:0] sel);
        if (sel == LDGRP_R_ACC) begin
            rd_reg = r.acc;
        end else if (sel == LDGRP_R_INVALID) begin
            rd_reg = 8'h00;
        end else begin
            rd_reg = r.gen[sel*8 +: 8];
        end
    endfunction

    // read a pair by pair field
    function automatic logic [15:0] rd_pair(input ldgrp_regs_t r, input logic [1:0] p);
        case (p)
            LDGRP_P_STACK: rd_pair = r.stack_ptr;
            default: rd_pair = {r.gen[p*16 +: 8], r.gen[p*16+8 +: 8]};
        endcase
    endfunction

    // memory pointer pair, or the prefixed index register
    function automatic logic [15:0] ptr_of(input ldgrp_regs_t r, input logic [1:0] pf);
        case (pf)
            2'h1: ptr_of = r.first_index_register;
            2'h2: ptr_of = r.second_index_register;
            default: ptr_of = {r.gen[LDGRP_R_H*8 +: 8], r.gen[LDGRP_R_L*8 +: 8]};
        endcase
    endfunction

    ldgrp_ea u_ea (
        .i_base(ea_base),
        .i_disp(disp_ff),
        .i_use_disp(ea_disp),
        .o_addr(ea_out)
    );

    // address adder operands: index plus displacement or address plus one
    always_comb begin
        ea_disp = (kind_ff == K_LDIND) || (kind_ff == K_STIND) || (kind_ff == K_STIMM);
        ea_base = ea_disp ? ptr_of(regs_ff, pfx_ff) : addr_ff;
    end

    // sequencer: next state, registers and bus request
    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_regs = regs_ff;
        nxt_req = req_ff;
        nxt_valid = valid_ff;
        nxt_pc = pc_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_disp = disp_ff;
        nxt_op = op_ff;
        nxt_pfx = pfx_ff;
        nxt_done = 1'b0;
        nxt_tst = tst_ff;
        nxt_tacc = tacc_ff;
        nxt_ill = ill_ff;
        case (state_ff)
            ST_FETCH: begin
                if (!valid_ff) begin
                    nxt_valid = 1'b1;
                    nxt_req = '{kind: LDGRP_BUS_FETCH, addr: pc_ff, wdata: 8'h00};
                end else if (i_mem_ack) begin
                    nxt_valid = 1'b0;
                    nxt_pc = 16'(pc_ff + 16'h0001);
                    nxt_tacc = 5'(tacc_ff + LDGRP_T_FETCH);
                    nxt_op = i_mem_rdata;
                    if (i_mem_rdata == LDGRP_PFX_IX && pfx_ff == 2'h0) begin
                        nxt_pfx = 2'h1;
                    end else if (i_mem_rdata == LDGRP_PFX_IY && pfx_ff == 2'h0) begin
                        nxt_pfx = 2'h2;
                    end else if (i_mem_rdata == LDGRP_PFX_EXT && pfx_ff == 2'h0) begin
                        nxt_pfx = 2'h3;
                    end else begin
                        nxt_state = ST_FETCH2;
                    end
                end
            end
            ST_FETCH2: begin
                // decode the fetched opcode
                nxt_state = ST_LO;
                nxt_kind = K_NONE;
                nxt_ill = 1'b0; // flag only reports the instruction just decoded
                if (pfx_ff == 2'h3) begin
                    if ((op_ff & LDGRP_MSK_ST_PAIR) == LDGRP_OP_ST_PAIR) begin
                        nxt_kind = K_ST16;
                        nxt_data = rd_pair(regs_ff, op_ff[5:4]);
                    end else if (op_ff == LDGRP_OP_LD_REFRESH) begin
                        nxt_kind = K_REFRESH;
                        nxt_state = ST_DONE;
                        nxt_regs.refresh = regs_ff.acc;
                        nxt_tacc = 5'(tacc_ff + 5'h01);
                    end
                end else if (op_ff[7:6] == 2'h1 && op_ff[5:0] != 6'h36) begin
                    if (op_ff[2:0] == 3'h6) begin
                        nxt_kind = K_LDIND;
                        nxt_state = (pfx_ff == 2'h0) ? ST_RD1 : ST_DISP;
                    end else if (op_ff[5:3] == 3'h6) begin
                        nxt_kind = K_STIND;
                        nxt_data = {8'h00, rd_reg(regs_ff, op_ff[2:0])};
                        nxt_state = (pfx_ff == 2'h0) ? ST_WR1 : ST_DISP;
                    end else begin
                        nxt_kind = K_MOVE;
                        nxt_state = ST_DONE;
                        if (op_ff[5:3] == LDGRP_R_ACC) begin
                            nxt_regs.acc = rd_reg(regs_ff, op_ff[2:0]);
                        end else begin
                            nxt_regs.gen[op_ff[5:3]*8 +: 8] = rd_reg(regs_ff, op_ff[2:0]);
                        end
                    end
                end else if (op_ff == LDGRP_OP_ST_IMM_IND) begin
                    nxt_kind = K_STIMM;
                    nxt_state = (pfx_ff == 2'h0) ? ST_IMM : ST_DISP;
                end else if (op_ff[7:6] == 2'h0 && op_ff[2:0] == 3'h6) begin
                    nxt_kind = K_LDIMM;
                    nxt_state = ST_IMM;
                end else if (op_ff == LDGRP_OP_ST_ACC && pfx_ff == 2'h0) begin
                    nxt_kind = K_STACC;
                    nxt_data = {8'h00, regs_ff.acc};
                end else if (op_ff == LDGRP_OP_ST_PAIR16) begin
                    nxt_kind = K_ST16;
                    nxt_data = ptr_of(regs_ff, pfx_ff);
                end else if (op_ff == LDGRP_OP_LD_IDX16 && pfx_ff != 2'h0) begin
                    nxt_kind = K_LD16;
                end
                if (nxt_kind == K_NONE) begin
                    nxt_ill = 1'b1;
                    nxt_state = ST_DONE;
                end
            end
            ST_DISP, ST_LO, ST_HI, ST_IMM, ST_RD1, ST_RD2, ST_WR1, ST_WR2: begin
                if (!valid_ff) begin
                    nxt_valid = 1'b1;
                    if (state_ff inside {ST_RD1, ST_RD2, ST_WR1, ST_WR2}) begin
                        nxt_req.addr = (state_ff inside {ST_RD1, ST_WR1}) && kind_ff != K_LD16
                            && kind_ff != K_ST16 && kind_ff != K_STACC
                            ? (pfx_ff == 2'h0 ? ptr_of(regs_ff, pfx_ff) : ea_out)
                            : (state_ff inside {ST_RD2, ST_WR2} ? ea_out : addr_ff);
                        nxt_req.kind = (state_ff inside {ST_RD1, ST_RD2}) ? LDGRP_BUS_READ
                            : LDGRP_BUS_WRITE;
                        nxt_req.wdata = (state_ff == ST_WR2) ? data_ff[15:8] : data_ff[7:0];
                    end else begin
                        nxt_req = '{kind: LDGRP_BUS_READ, addr: pc_ff, wdata: 8'h00};
                    end
                end else if (i_mem_ack) begin
                    nxt_valid = 1'b0;
                    nxt_tacc = 5'(tacc_ff + LDGRP_T_MEM);
                    case (state_ff)
                        ST_DISP: begin
                            nxt_pc = 16'(pc_ff + 16'h0001);
                            nxt_disp = i_mem_rdata;
                            // address add overlaps the immediate fetch of the store
                            nxt_tacc = (kind_ff == K_STIMM) ? 5'(tacc_ff + LDGRP_T_MEM)
                                : 5'(tacc_ff + LDGRP_T_MEM + LDGRP_T_ADDR);
                            nxt_state = (kind_ff == K_STIMM) ? ST_IMM
                                : (kind_ff == K_LDIND) ? ST_RD1 : ST_WR1;
                        end
                        ST_LO: begin
                            nxt_pc = 16'(pc_ff + 16'h0001);
                            nxt_addr[7:0] = i_mem_rdata;
                            nxt_state = ST_HI;
                        end
                        ST_HI: begin
                            nxt_pc = 16'(pc_ff + 16'h0001);
                            nxt_addr[15:8] = i_mem_rdata;
                            nxt_state = (kind_ff == K_LD16) ? ST_RD1 : ST_WR1;
                        end
                        ST_IMM: begin
                            nxt_pc = 16'(pc_ff + 16'h0001);
                            if (kind_ff == K_STIMM) begin
                                nxt_data = {8'h00, i_mem_rdata};
                                nxt_state = ST_WR1;
                                if (pfx_ff != 2'h0) begin
                                    nxt_tacc = 5'(tacc_ff + LDGRP_T_ADDR);
                                end
                            end else begin
                                if (op_ff[5:3] == LDGRP_R_ACC) begin
                                    nxt_regs.acc = i_mem_rdata;
                                end else if (op_ff[5:3] != LDGRP_R_INVALID) begin
                                    nxt_regs.gen[op_ff[5:3]*8 +: 8] = i_mem_rdata;
                                end
                                nxt_state = ST_DONE;
                            end
                        end
                        ST_RD1: begin
                            if (kind_ff == K_LD16) begin
                                nxt_data[7:0] = i_mem_rdata;
                                nxt_state = ST_RD2;
                            end else begin
                                if (op_ff[5:3] == LDGRP_R_ACC) begin
                                    nxt_regs.acc = i_mem_rdata;
                                end else if (op_ff[5:3] != LDGRP_R_INVALID) begin
                                    nxt_regs.gen[op_ff[5:3]*8 +: 8] = i_mem_rdata;
                                end
                                nxt_state = ST_DONE;
                            end
                        end
                        ST_RD2: begin
                            if (pfx_ff == 2'h1) begin
                                nxt_regs.first_index_register = {i_mem_rdata, data_ff[7:0]};
                            end else begin
                                nxt_regs.second_index_register = {i_mem_rdata, data_ff[7:0]};
                            end
                            nxt_state = ST_DONE;
                        end
                        ST_WR1: begin
                            nxt_state = (kind_ff == K_ST16 || kind_ff == K_LD16) ? ST_WR2
                                : ST_DONE;
                        end
                        default: begin
                            nxt_state = ST_DONE;
                            // unprefixed pointer store counts one state beyond its bus cycles
                            if (kind_ff == K_ST16 && pfx_ff == 2'h0) begin
                                nxt_tacc = 5'(tacc_ff + LDGRP_T_MEM + 5'h01);
                            end
                        end
                    endcase
                end
            end
            default: begin
                // retire: report the clock state total, flags untouched
                nxt_done = 1'b1;
                nxt_tst = tacc_ff;
                nxt_tacc = 5'h00;
                nxt_pfx = 2'h0;
                nxt_state = ST_FETCH;
            end
        endcase
        nxt_regs.flags = regs_ff.flags;
    end

    // state registers; reset puts the core at its start address
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= ST_FETCH;
            kind_ff <= K_NONE;
            regs_ff <= '0;
            req_ff <= '0;
            valid_ff <= 1'b0;
            pc_ff <= START_PC;
            addr_ff <= 16'h0000;
            data_ff <= 16'h0000;
            disp_ff <= 8'h00;
            op_ff <= 8'h00;
            pfx_ff <= 2'h0;
            done_ff <= 1'b0;
            tst_ff <= 5'h00;
            tacc_ff <= 5'h00;
            ill_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            regs_ff <= nxt_regs;
            req_ff <= nxt_req;
            valid_ff <= nxt_valid;
            pc_ff <= nxt_pc;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            disp_ff <= nxt_disp;
            op_ff <= nxt_op;
            pfx_ff <= nxt_pfx;
            done_ff <= nxt_done;
            tst_ff <= nxt_tst;
            tacc_ff <= nxt_tacc;
            ill_ff <= nxt_ill;
        end
    end

    assign o_mem_req = req_ff;
    assign o_mem_valid = valid_ff;
    assign o_regs = regs_ff;
    assign o_pc = pc_ff;
    assign o_done = done_ff;
    assign o_tstates = tst_ff;
    assign o_illegal = ill_ff;

    // checks on observable behaviour
    AST_FLAGS_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        ##1 regs_ff.flags == $past(regs_ff.flags)) else $error("flags changed");
    AST_MOVE_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_MOVE |-> tst_ff == LDGRP_T_MOVE) else $error("move time");
    AST_STACC_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_STACC |-> tst_ff == LDGRP_T_ST_ACC) else $error("acc store");
    AST_IND_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_LDIND && $past(pfx_ff) == 2'h0 |-> tst_ff == LDGRP_T_IND)
        else $error("indirect load time");
    AST_IDX_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff inside {K_LDIND, K_STIND, K_STIMM} && $past(pfx_ff) != 2'h0
        |-> tst_ff == LDGRP_T_INDEXED) else $error("indexed time");
    AST_REFRESH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_REFRESH |-> tst_ff == LDGRP_T_REFRESH
        && regs_ff.refresh == regs_ff.acc) else $error("refresh load");
    AST_ST16_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_ST16 && $past(pfx_ff) != 2'h0 |-> tst_ff == LDGRP_T_ABS16)
        else $error("pair store time");
    AST_HL_TIME: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        done_ff && kind_ff == K_ST16 && $past(pfx_ff) == 2'h0 |-> tst_ff == LDGRP_T_ST_MPTR)
        else $error("pointer store time");
endmodule
`default_nettype wire

// ==== ldgrp_ea.sv ====
// effective address adder: index plus signed displacement, or address plus one
`timescale 1ns/100ps
`default_nettype none
module ldgrp_ea (
    input wire logic [15:0] i_base,
    input wire logic [7:0] i_disp,
    input wire logic i_use_disp,
    output logic [15:0] o_addr
);
    logic [15:0] offset;
    // sign extension lets the address fall below the base
    always_comb begin
        offset = i_use_disp ? {{8{i_disp[7]}}, i_disp} : 16'h0001;
        o_addr = 16'(i_base + offset);
    end
endmodule
`default_nettype wire

// ==== ldgrp_mem_model.sv ====
// behavioural memory answering the executor's fetch, read and write requests
`timescale 1ns/100ps
`default_nettype none
module ldgrp_mem_model
    import ldgrp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_slow,
    input wire ldgrp_pkg::ldgrp_req_t i_mem_req,
    input wire logic i_mem_valid,
    output logic o_mem_ack,
    output logic [7:0] o_mem_rdata
);
    import ldgrp_pkg::*;
    logic [7:0] mem [65536];
    int wait_cnt;
    initial begin
        o_mem_ack = 1'b0;
        o_mem_rdata = 8'h00;
        wait_cnt = 0;
    end
    // slow mode adds three wait cycles; data toggles when not answering so stale bytes show
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mem_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (o_mem_ack || !i_mem_valid) begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            wait_cnt <= 0;
        end else if (i_slow && wait_cnt < 3) begin
            wait_cnt <= wait_cnt + 1;
            o_mem_rdata <= ~o_mem_rdata;
        end else begin
            o_mem_ack <= 1'b1;
            o_mem_rdata <= mem[i_mem_req.addr];
            if (i_mem_req.kind == LDGRP_BUS_WRITE) mem[i_mem_req.addr] <= i_mem_req.wdata;
        end
    end
endmodule
`default_nettype wire

// ==== ldgrp_pkg.sv ====
// shared constants and types for the load instruction group executor
package ldgrp_pkg;
    // bus cycle kinds
    localparam logic [1:0] LDGRP_BUS_FETCH = 2'h0;
    localparam logic [1:0] LDGRP_BUS_READ = 2'h1;
    localparam logic [1:0] LDGRP_BUS_WRITE = 2'h2;
    // register select codes
    localparam logic [2:0] LDGRP_R_ACC = 3'h7;
    localparam logic [2:0] LDGRP_R_INVALID = 3'h6;
    localparam logic [2:0] LDGRP_R_H = 3'h4;
    localparam logic [2:0] LDGRP_R_L = 3'h5;
    // pair select codes
    localparam logic [1:0] LDGRP_P_COUNT = 2'h0;
    localparam logic [1:0] LDGRP_P_DEST = 2'h1;
    localparam logic [1:0] LDGRP_P_MPTR = 2'h2;
    localparam logic [1:0] LDGRP_P_STACK = 2'h3;
    // opcodes and prefixes
    localparam logic [7:0] LDGRP_PFX_IX = 8'hdd;
    localparam logic [7:0] LDGRP_PFX_IY = 8'hfd;
    localparam logic [7:0] LDGRP_PFX_EXT = 8'hed;
    localparam logic [7:0] LDGRP_OP_ST_ACC = 8'h32;
    localparam logic [7:0] LDGRP_OP_ST_PAIR16 = 8'h22;
    localparam logic [7:0] LDGRP_OP_ST_IMM_IND = 8'h36;
    localparam logic [7:0] LDGRP_OP_LD_REFRESH = 8'h4f;
    localparam logic [7:0] LDGRP_OP_LD_IDX16 = 8'h2a;
    localparam logic [7:0] LDGRP_MSK_ST_PAIR = 8'hcf;
    localparam logic [7:0] LDGRP_OP_ST_PAIR = 8'h43;
    // clock state counts per instruction and per machine cycle
    localparam logic [4:0] LDGRP_T_MOVE = 5'h04;
    localparam logic [4:0] LDGRP_T_IND = 5'h07;
    localparam logic [4:0] LDGRP_T_REFRESH = 5'h09;
    localparam logic [4:0] LDGRP_T_ST_ACC = 5'h0d;
    localparam logic [4:0] LDGRP_T_ST_MPTR = 5'h11;
    localparam logic [4:0] LDGRP_T_INDEXED = 5'h13;
    localparam logic [4:0] LDGRP_T_ABS16 = 5'h14;
    localparam logic [4:0] LDGRP_T_FETCH = 5'h04;
    localparam logic [4:0] LDGRP_T_MEM = 5'h03;
    localparam logic [4:0] LDGRP_T_ADDR = 5'h05;

    // one memory bus request
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ldgrp_req_t;

    // architectural register file view
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] refresh;
        logic [15:0] stack_ptr;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
        logic [63:0] gen;
    } ldgrp_regs_t;
endpackage

// ==== testbench.sv ====
// self-checking bench for the load instruction group executor
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ldgrp_pkg::*;
    typedef struct {
        logic [31:0] code;
        int n;
        logic [4:0] t;
        int k;
        logic [15:0] a;
        logic [15:0] v;
    } ldgrp_row_t;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic slow = 1'b0;
    logic i_mem_ack;
    logic [7:0] i_mem_rdata;
    ldgrp_req_t o_mem_req;
    logic o_mem_valid;
    ldgrp_regs_t o_regs;
    logic [15:0] o_pc;
    logic o_done;
    logic [4:0] o_tstates;
    logic o_illegal;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int at = 0;
    ldgrp_row_t rows[$];

    ldgrp_core #(.START_PC(16'h0000)) ldgrp_core_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req),
        .o_mem_valid(o_mem_valid), .o_regs(o_regs), .o_pc(o_pc), .o_done(o_done),
        .o_tstates(o_tstates), .o_illegal(o_illegal));
    ldgrp_mem_model ldgrp_mem_model_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_slow(slow), .i_mem_req(o_mem_req), .i_mem_valid(o_mem_valid),
        .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

    always #5 i_sys_clk = ~i_sys_clk;

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the program needs, even with wait states
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR timeout expected done seen hang");
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // places the opcode bytes in memory back to back and queues the expectation
    task automatic row(input logic [31:0] c, input int n, input logic [4:0] t, input int k,
                       input logic [15:0] a, input logic [15:0] v);
        for (int i = 0; i < n; i++) begin
            ldgrp_mem_model_i.mem[at] = c[31 - 8 * i -: 8];
            at++;
        end
        rows.push_back('{c, n, t, k, a, v});
    endtask

    // sampled at the falling edge so the one-cycle pulse is never raced
    task automatic wait_done();
        int w;
        w = 0;
        do begin
            @(negedge i_sys_clk);
            w++;
        end while (o_done !== 1'b1 && w < 400);
        if (w >= 400) check("done", 16'h0000, 16'h0001);
    endtask

    // k: 0 general register, 1 memory byte, 2 accumulator, 3 refresh, else second index
    function automatic logic [15:0] seen(input int k, input logic [15:0] a);
        case (k)
            0: return {8'h00, o_regs.gen[{a[2:0], 3'h0} +: 8]};
            1: return {8'h00, ldgrp_mem_model_i.mem[a]};
            2: return {8'h00, o_regs.acc};
            3: return {8'h00, o_regs.refresh};
            default: return o_regs.second_index_register;
        endcase
    endfunction

    initial begin
        for (int i = 0; i < 65536; i++) ldgrp_mem_model_i.mem[i] = 8'hee;
        ldgrp_mem_model_i.mem[16'h4010] = 8'h3c;
        ldgrp_mem_model_i.mem[16'h5000] = 8'h34;
        ldgrp_mem_model_i.mem[16'h5001] = 8'ha2;
        ldgrp_mem_model_i.mem[16'ha2b3] = 8'h6b;
        row(32'h3e5a0000, 2, 5'h07, 2, 16'h0000, 16'h005a);
        row(32'h06120000, 2, 5'h07, 0, 16'h0000, 16'h0012);
        row(32'h26400000, 2, 5'h07, 0, 16'h0004, 16'h0040);
        row(32'h2e100000, 2, 5'h07, 0, 16'h0005, 16'h0010);
        row(32'h16770000, 2, 5'h07, 0, 16'h0002, 16'h0077);
        row(32'h48000000, 1, 5'h04, 0, 16'h0001, 16'h0012);
        row(32'h32003000, 3, 5'h0d, 1, 16'h3000, 16'h005a);
        row(32'h22feff00, 3, 5'h11, 1, 16'hffff, 16'h0040);
        row(32'hed430031, 4, 5'h14, 1, 16'h3101, 16'h0012);
        row(32'hed531031, 4, 5'h14, 1, 16'h3111, 16'h0077);
        row(32'hed632031, 4, 5'h14, 1, 16'h3121, 16'h0040);
        row(32'hed733031, 4, 5'h14, 1, 16'h3131, 16'h0000);
        row(32'hed4f0000, 2, 5'h09, 3, 16'h0000, 16'h005a);
        row(32'h7e000000, 1, 5'h07, 2, 16'h0000, 16'h003c);
        row(32'hdd36fe99, 4, 5'h13, 1, 16'hfffe, 16'h0099);
        row(32'hfd2a0050, 4, 5'h14, 4, 16'h0000, 16'ha234);
        row(32'hfd368077, 4, 5'h13, 1, 16'ha1b4, 16'h0077);
        row(32'hfd710500, 3, 5'h13, 1, 16'ha239, 16'h0012);
        row(32'hfd5e7f00, 3, 5'h13, 0, 16'h0003, 16'h006b);
        row(32'hdd560000, 3, 5'h13, 0, 16'h0002, 16'h003e);
        row(32'hdd220032, 4, 5'h14, 1, 16'h3201, 16'h0000);
        row(32'hfd221032, 4, 5'h14, 1, 16'h3211, 16'h00a2);
        ldgrp_mem_model_i.mem[at] = 8'hed;
        ldgrp_mem_model_i.mem[at + 1] = 8'h00;
        repeat (16) @(posedge i_sys_clk);
        check("reset pc", o_pc, 16'h0000);
        #1 i_sys_rst = 1'b0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("first fetch", {o_mem_valid, o_mem_req.kind, o_mem_req.addr[12:0]}, 16'h8000);
        foreach (rows[i]) begin
            @(posedge i_sys_clk);
            #1 slow = i[0];
            wait_done();
            check("tstates", {11'h000, o_tstates}, {11'h000, rows[i].t});
            check("flags", {8'h00, o_regs.flags}, 16'h0000);
            @(negedge i_sys_clk);
            check("value", seen(rows[i].k, rows[i].a), rows[i].v);
        end
        // unknown extended opcode retires flagged and leaves the accumulator alone
        wait_done();
        check("illegal", {o_illegal, o_regs.acc}, 16'h013c);
        // reset in mid-run clears state and restarts fetching at the start address
        @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b1;
        @(negedge i_sys_clk);
        check("rerun valid", {15'h0000, o_mem_valid}, 16'h0000);
        check("rerun index", o_regs.second_index_register, 16'h0000);
        @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("rerun fetch", {o_mem_valid, o_mem_req.kind, o_mem_req.addr[12:0]}, 16'h8000);
        results();
    end
endmodule
`default_nettype wire
